// [sim/relay_bank.sv]
// Relay contacts on the sequence inputs, wired sink or source
`timescale 1ns/1ns
module relay_bank (
  input wire logic wiring_source,
  input wire logic [6:0] closed,
  output logic [6:0] in_pin
);
  // Sink: closed pulls to 0 V; source: closed applies 24 V
  assign in_pin = wiring_source ? closed : ~closed;
endmodule

// [sim/sig_alloc_properties.sv]
// Port-level properties of the signal allocation block
`timescale 1ns/1ns
module sig_alloc_properties (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic param_wr,
  input wire logic [2:0] param_idx,
  input wire logic [15:0] param_wdata,
  input wire logic power_cycle,
  input wire logic wiring_source,
  input wire logic [sig_alloc_pkg::NUM_IN_PINS-1:0] in_pin,
  input wire sig_alloc_pkg::ctrl_mode_type ctrl_mode,
  input wire sig_alloc_pkg::status_type status,
  input wire logic [15:0] param_rdata,
  input wire logic [15:0] active_rdata,
  input wire logic cfg_loaded,
  input wire sig_alloc_pkg::seq_in_type seq_in,
  input wire sig_alloc_pkg::seq_in_type input_monitor,
  input wire logic [sig_alloc_pkg::NUM_OUT_PINS-1:0] out_pin_on
);
  logic [2:0] inv_reg;
  logic known_reg;
  logic [2:0] idx_q_reg;
  logic cfg_q_reg;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Active invert bits are learnt from readback; unknown until read again
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      inv_reg <= 3'h0;
      known_reg <= 1'b1;
      idx_q_reg <= 3'h0;
      cfg_q_reg <= 1'b0;
    end else begin
      idx_q_reg <= param_idx;
      cfg_q_reg <= cfg_loaded;
      if (power_cycle) begin
        known_reg <= 1'b0;
      end else if (cfg_loaded && cfg_q_reg &&
                   idx_q_reg == sig_alloc_pkg::IDX_OUTPUT_INVERT) begin
        inv_reg <= active_rdata[2:0];
        known_reg <= 1'b1;
      end
    end
  end
  sequence s_reload;
    !cfg_loaded ##1 cfg_loaded;
  endsequence
  sequence s_steady;
    cfg_loaded && $past(cfg_loaded);
  endsequence
  property p_reload;
    power_cycle |=> s_reload;
  endproperty
  property p_keep;
    cfg_loaded && !power_cycle |=> cfg_loaded;
  endproperty
  property p_hold;
    s_steady and $stable(param_idx) |=> $stable(active_rdata);
  endproperty
  property p_saved;
    param_wr && param_idx < 3'h6 |=> param_rdata == $past(param_wdata);
  endproperty
  property p_unused;
    param_idx > 3'h5 |=> param_rdata == 16'h0000 && active_rdata == 16'h0000;
  endproperty
  property p_in_steady;
    s_steady and $stable(in_pin) && $stable(wiring_source) |=>
      $stable(seq_in);
  endproperty
  property p_out_steady;
    s_steady and $stable(status) && $stable(ctrl_mode) |=>
      $stable(out_pin_on);
  endproperty
  property p_idle;
    known_reg && status == 10'h000 |=> out_pin_on == $past(inv_reg);
  endproperty
  property p_monitor;
    input_monitor == seq_in;
  endproperty
  a_reload: assert property (p_reload) else $error("no reload");
  a_keep: assert property (p_keep) else $error("load lost");
  a_hold: assert property (p_hold) else $error("routing moved");
  a_saved: assert property (p_saved) else $error("saved value");
  a_unused: assert property (p_unused) else $error("unused index");
  a_in_steady: assert property (p_in_steady) else $error("input drift");
  a_out_steady: assert property (p_out_steady) else $error("out drift");
  a_idle: assert property (p_idle) else $error("idle pin level");
  a_monitor: assert property (p_monitor) else $error("monitor");
endmodule
bind sig_alloc sig_alloc_properties i_props (.sys_clk(sys_clk),
  .arst_n(arst_n), .param_wr(param_wr), .param_idx(param_idx),
  .param_wdata(param_wdata), .power_cycle(power_cycle),
  .wiring_source(wiring_source), .in_pin(in_pin), .ctrl_mode(ctrl_mode),
  .status(status), .param_rdata(param_rdata), .active_rdata(active_rdata),
  .cfg_loaded(cfg_loaded), .seq_in(seq_in), .input_monitor(input_monitor),
  .out_pin_on(out_pin_on));

// [sim/test_servo_io_signal_allocation.sv]
// Self-checking bench of the signal allocation block
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
  n_errors++; $display("mismatch %s exp %h got %h", nm, e, g); end end
module test_servo_io_signal_allocation;
  logic sys_clk = 0, arst_n = 0, param_wr = 0, power_cycle = 0;
  logic wiring_source = 0, cfg_loaded;
  logic [2:0] param_idx = 3'h0, out_pin_on;
  logic [15:0] param_wdata = 16'h0000, param_rdata, active_rdata;
  logic [6:0] closed = 7'h00, in_pin;
  sig_alloc_pkg::ctrl_mode_type ctrl_mode = sig_alloc_pkg::MODE_POSITION;
  sig_alloc_pkg::status_type status = 10'h000;
  sig_alloc_pkg::seq_in_type seq_in, input_monitor;
  int n_errors = 0, total_checks = 0, cyc = 0;
  int saved[8] = '{sig_alloc_pkg::RST_INPUT_MAP_A,
    sig_alloc_pkg::RST_INPUT_MAP_B, sig_alloc_pkg::RST_OUTPUT_MAP_A,
    sig_alloc_pkg::RST_OUTPUT_MAP_B, sig_alloc_pkg::RST_OUTPUT_MAP_C,
    sig_alloc_pkg::RST_OUTPUT_INVERT, 0, 0};
  int act[8];
  logic [31:0] rng = 32'h000166e2;
  always #10 sys_clk = ~sys_clk;
  relay_bank i_relays (.wiring_source(wiring_source), .closed(closed),
    .in_pin(in_pin));
  sig_alloc i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .param_wr(param_wr),
    .param_idx(param_idx), .param_wdata(param_wdata),
    .power_cycle(power_cycle), .wiring_source(wiring_source),
    .in_pin(in_pin), .ctrl_mode(ctrl_mode), .status(status),
    .param_rdata(param_rdata), .active_rdata(active_rdata),
    .cfg_loaded(cfg_loaded), .seq_in(seq_in), .input_monitor(input_monitor),
    .out_pin_on(out_pin_on));
  function automatic logic [31:0] next_rand();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic int dig(int w, int d);
    return (w >> (4 * d)) & 15;
  endfunction
  function automatic logic [6:0] exp_in();
    int a = act[0];
    int b = act[1];
    int d;
    logic [6:0] r;
    if (dig(a, 0) != sig_alloc_pkg::FREE_ALLOC_ON) begin
      a = sig_alloc_pkg::RST_INPUT_MAP_A;
      b = sig_alloc_pkg::RST_INPUT_MAP_B;
    end
    for (int i = 0; i < 7; i++) begin
      d = i < 3 ? dig(a, i + 1) : dig(b, i - 3);
      r[i] = d == 7 ? 1'b1 : d == 8 ? 1'b0 :
        d < 7 ? closed[d] : !closed[d - 9];
    end
    return r;
  endfunction
  function automatic logic [2:0] exp_out();
    logic [2:0] o = 3'h0;
    logic ok;
    int d;
    for (int i = 0; i < 10; i++) begin
      d = dig(act[2 + i / 4], i < 8 ? i % 4 : (i - 8) * 2);
      ok = 1'b1;
      if (i == 0 || i == 8) ok = ctrl_mode == sig_alloc_pkg::MODE_POSITION;
      if (i == 1) ok = ctrl_mode == sig_alloc_pkg::MODE_SPEED;
      if (i == 5) ok = ctrl_mode == sig_alloc_pkg::MODE_TORQUE;
      if (d >= 1 && d <= 3 && ok && status[i]) o[d - 1] = 1'b1;
    end
    return o ^ act[5][2:0];
  endfunction
  task automatic cfg(input int v[6]);
    for (int i = 0; i < 6; i++) begin
      param_wr = 1;
      param_idx = i[2:0];
      param_wdata = v[i][15:0];
      saved[i] = v[i];
      @(negedge sys_clk);
    end
    param_wr = 0;
  endtask
  task automatic rd_all();
    for (int i = 0; i < 8; i++) begin
      param_idx = i[2:0];
      @(negedge sys_clk);
      `CHK("saved", saved[i][15:0], param_rdata)
      `CHK("active", act[i][15:0], active_rdata)
    end
  endtask
  task automatic pc();
    // Quiet status lets the idle pin levels show the new inversion
    status = '0;
    power_cycle = 1;
    @(negedge sys_clk);
    power_cycle = 0;
    `CHK("reload", 1'b0, cfg_loaded)
    for (int k = 0; k < 8 && cfg_loaded !== 1'b1; k++) @(negedge sys_clk);
    `CHK("loaded", 1'b1, cfg_loaded)
    act = saved;
    rd_all();
    `CHK("idle", act[5][2:0], out_pin_on)
  endtask
  task automatic rnd(int n);
    logic [31:0] r;
    for (int k = 0; k < n; k++) begin
      r = next_rand();
      status = sig_alloc_pkg::status_type'(r[9:0]);
      closed = r[16:10];
      wiring_source = r[17];
      ctrl_mode = sig_alloc_pkg::ctrl_mode_type'(r[19:18] % 2'h3);
      @(negedge sys_clk);
      `CHK("outputs", exp_out(), out_pin_on)
      `CHK("inputs", exp_in(), seq_in)
      `CHK("monitor", exp_in(), input_monitor)
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end
  initial begin
    act = saved;
    repeat (20) @(negedge sys_clk);
    arst_n = 1;
    @(negedge sys_clk);
    rd_all();
    rnd(40);
    $display("test 1 done");
    cfg('{16'h2151, 16'h6043, 16'h3011, 0, 0, 0});
    rd_all();
    rnd(20);
    pc();
    rnd(40);
    $display("test 2 done");
    // Brake shares pin 2, which stays uninverted
    cfg('{16'h87f1, 16'h9a0c, 16'h0211, 16'h1211, 16'h0302, 5});
    pc();
    rnd(60);
    $display("test 3 done");
    cfg('{16'h87f0, 16'h9a0c, 0, 0, 0, 7});
    pc();
    rnd(30);
    $display("test 4 done");
    final_report();
  end
endmodule

// [verilog/out_pin_driver.sv]
// One output pin pair: OR of routed signals, then polarity inversion
`timescale 1ns/1ns
module out_pin_driver #(
  parameter int N = 10
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [N-1:0] routed,
  input wire logic invert,
  output logic pin_on
);

  logic pin_next;

  always_comb begin
    // Nothing routed leaves the OR low, the inactive level
    pin_next = (|routed) ^ invert;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_on <= 1'b0;
    end else begin
      pin_on <= pin_next;
    end
  end

endmodule

// [verilog/sig_alloc.sv]
// Sequence I/O signal allocation between internal signals and connector
`timescale 1ns/1ns
// Operation
// - Output digit 1, 2, 3 picks pin pair one to three; 0 leaves unused.
// - Output map A digits route positioning, speed match, rotation, ready.
// - Map B routes limits, brake, warning; map C near and pulse ack.
// - Signals sharing one output pin pair are ORed together.
// - Signals not evaluated in the current control mode count as inactive.
// - Invert register bits 0 to 2 invert pin pairs one to three.
// - New allocation settings apply only after a power cycle.
// - Input map A digit 0 set to 1 enables free input allocation.
// - Input map A digit 1 places servo_on_in; 0 first pin, 5 sixth.
// - Input map B digit 2 places fwd_torque_limit_in; 5 sixth, 0 first.
// - Sink wiring reads low as ON; source wiring reverses that.
// - All sequence input states are readable as input_monitor.
module sig_alloc (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic param_wr,
  input wire logic [2:0] param_idx,
  input wire logic [15:0] param_wdata,
  input wire logic power_cycle,
  input wire logic wiring_source,
  input wire logic [sig_alloc_pkg::NUM_IN_PINS-1:0] in_pin,
  input wire sig_alloc_pkg::ctrl_mode_type ctrl_mode,
  input wire sig_alloc_pkg::status_type status,
  output logic [15:0] param_rdata,
  output logic [15:0] active_rdata,
  output logic cfg_loaded,
  output sig_alloc_pkg::seq_in_type seq_in,
  output sig_alloc_pkg::seq_in_type input_monitor,
  output logic [sig_alloc_pkg::NUM_OUT_PINS-1:0] out_pin_on
);

  localparam int NO = sig_alloc_pkg::NUM_OUT_SIGS;
  localparam int NI = sig_alloc_pkg::NUM_IN_SIGS;

  function automatic logic [3:0] digit_of(input logic [15:0] v,
                                         input int d);
    digit_of = v[d*sig_alloc_pkg::DIGIT_W +: sig_alloc_pkg::DIGIT_W];
  endfunction

  // Resolve one input digit against the ON levels of the pins
  function automatic logic in_select(input logic [3:0] dig,
                                     input logic [6:0] on);
    logic [3:0] idx;
    idx = 4'h0;
    if (dig < sig_alloc_pkg::IN_ALWAYS_ON) begin
      in_select = on[dig[2:0]];
    end else if (dig == sig_alloc_pkg::IN_ALWAYS_ON) begin
      in_select = 1'b1;
    end else if (dig == sig_alloc_pkg::IN_ALWAYS_OFF) begin
      in_select = 1'b0;
    end else begin
      idx = dig - sig_alloc_pkg::IN_INV_BASE;
      in_select = ~on[idx[2:0]];
    end
  endfunction

  // Reset loads a plain constant so the async branch stays glitch free
  localparam sig_alloc_pkg::cfg_type FACTORY_CFG = {
    sig_alloc_pkg::RST_OUTPUT_INVERT, sig_alloc_pkg::RST_OUTPUT_MAP_C,
    sig_alloc_pkg::RST_OUTPUT_MAP_B, sig_alloc_pkg::RST_OUTPUT_MAP_A,
    sig_alloc_pkg::RST_INPUT_MAP_B, sig_alloc_pkg::RST_INPUT_MAP_A};

  function automatic logic [15:0] cfg_word(input sig_alloc_pkg::cfg_type c,
                                           input logic [2:0] idx);
    case (idx)
      sig_alloc_pkg::IDX_INPUT_MAP_A: cfg_word = c.input_map_a;
      sig_alloc_pkg::IDX_INPUT_MAP_B: cfg_word = c.input_map_b;
      sig_alloc_pkg::IDX_OUTPUT_MAP_A: cfg_word = c.output_map_a;
      sig_alloc_pkg::IDX_OUTPUT_MAP_B: cfg_word = c.output_map_b;
      sig_alloc_pkg::IDX_OUTPUT_MAP_C: cfg_word = c.output_map_c;
      sig_alloc_pkg::IDX_OUTPUT_INVERT: cfg_word = c.output_invert;
      default: cfg_word = 16'h0000;
    endcase
  endfunction

  // Saved settings and the settings that steer the routing
  sig_alloc_pkg::cfg_type saved_reg, saved_next;
  sig_alloc_pkg::cfg_type active_reg, active_next;
  sig_alloc_pkg::boot_state_type boot_reg, boot_next;
  logic [15:0] rdata_next, active_rdata_next;
  logic loaded_next;

  always_comb begin
    saved_next = saved_reg;
    if (param_wr) begin
      case (param_idx)
        sig_alloc_pkg::IDX_INPUT_MAP_A: saved_next.input_map_a = param_wdata;
        sig_alloc_pkg::IDX_INPUT_MAP_B: saved_next.input_map_b = param_wdata;
        sig_alloc_pkg::IDX_OUTPUT_MAP_A:
          saved_next.output_map_a = param_wdata;
        sig_alloc_pkg::IDX_OUTPUT_MAP_B:
          saved_next.output_map_b = param_wdata;
        sig_alloc_pkg::IDX_OUTPUT_MAP_C:
          saved_next.output_map_c = param_wdata;
        sig_alloc_pkg::IDX_OUTPUT_INVERT:
          saved_next.output_invert = param_wdata;
        default: saved_next = saved_reg;
      endcase
    end
    // Writes land in the saved copy only; routing keeps the active copy
    active_next = active_reg;
    boot_next = boot_reg;
    case (boot_reg)
      sig_alloc_pkg::BOOT_LOAD: begin
        active_next = saved_reg;
        boot_next = sig_alloc_pkg::RUN;
      end
      sig_alloc_pkg::RUN: begin
        if (power_cycle) begin
          boot_next = sig_alloc_pkg::BOOT_LOAD;
        end
      end
      default: boot_next = sig_alloc_pkg::BOOT_LOAD;
    endcase
    loaded_next = (boot_next == sig_alloc_pkg::RUN);
    rdata_next = cfg_word(saved_next, param_idx);
    active_rdata_next = cfg_word(active_next, param_idx);
  end

  // Saved copy survives power_cycle, as a stored parameter would
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      saved_reg <= FACTORY_CFG;
      active_reg <= FACTORY_CFG;
      boot_reg <= sig_alloc_pkg::BOOT_LOAD;
      param_rdata <= 16'h0000;
      active_rdata <= 16'h0000;
      cfg_loaded <= 1'b0;
    end else begin
      saved_reg <= saved_next;
      active_reg <= active_next;
      boot_reg <= boot_next;
      param_rdata <= rdata_next;
      active_rdata <= active_rdata_next;
      cfg_loaded <= loaded_next;
    end
  end

  // Input side
  logic [sig_alloc_pkg::NUM_IN_PINS-1:0] pin_on;
  logic [15:0] in_map_a, in_map_b;
  logic [NI*4-1:0] in_digits;
  logic [NI-1:0] in_vec;
  sig_alloc_pkg::seq_in_type seq_in_next;

  always_comb begin
    pin_on = wiring_source ? in_pin : ~in_pin;
    // Fixed allocation falls back to the factory map
    if (digit_of(active_reg.input_map_a, 0) == sig_alloc_pkg::FREE_ALLOC_ON)
    begin
      in_map_a = active_reg.input_map_a;
      in_map_b = active_reg.input_map_b;
    end else begin
      in_map_a = sig_alloc_pkg::RST_INPUT_MAP_A;
      in_map_b = sig_alloc_pkg::RST_INPUT_MAP_B;
    end
    // Input map A digit 0 is the mode switch, so signals start at digit 1
    in_digits = {in_map_b, in_map_a[15:4]};
    for (int i = 0; i < NI; i++) begin
      in_vec[i] = in_select(in_digits[i*4 +: 4], pin_on);
    end
    seq_in_next = sig_alloc_pkg::seq_in_type'(in_vec);
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_in <= '0;
      input_monitor <= '0;
    end else begin
      seq_in <= seq_in_next;
      input_monitor <= seq_in_next;
    end
  end

  // Output side
  sig_alloc_pkg::status_type valid_sig;
  logic [NO*4-1:0] out_digits;
  logic [NO-1:0] routed [sig_alloc_pkg::NUM_OUT_PINS];

  always_comb begin
    valid_sig = status;
    // Signals without meaning in this mode are dropped before the OR
    if (ctrl_mode != sig_alloc_pkg::MODE_POSITION) begin
      valid_sig.positioning_done = 1'b0;
      valid_sig.near_position = 1'b0;
    end
    if (ctrl_mode != sig_alloc_pkg::MODE_SPEED) begin
      valid_sig.speed_match = 1'b0;
    end
    if (ctrl_mode != sig_alloc_pkg::MODE_TORQUE) begin
      valid_sig.speed_limited = 1'b0;
    end
    out_digits = {digit_of(active_reg.output_map_c, 2),
                  digit_of(active_reg.output_map_c, 0),
                  active_reg.output_map_b,
                  active_reg.output_map_a};
    for (int p = 0; p < sig_alloc_pkg::NUM_OUT_PINS; p++) begin
      for (int s = 0; s < NO; s++) begin
        // Digit 0 matches no pin, leaving the signal unused
        routed[p][s] = valid_sig[s] &&
          (out_digits[s*4 +: 4] == 4'(p + 1));
      end
    end
  end

  // Brake inversion is not blocked; that stays a configuration choice
  generate
    for (genvar g = 0; g < sig_alloc_pkg::NUM_OUT_PINS; g++) begin : g_pin
      out_pin_driver #(
        .N(NO)
      ) u_drv (
        .sys_clk(sys_clk),
        .arst_n(arst_n),
        .routed(routed[g]),
        .invert(active_reg.output_invert[g]),
        .pin_on(out_pin_on[g])
      );
    end
  endgenerate

endmodule

// [verilog/sig_alloc_pkg.sv]
// Constants, types and factory settings of the sequence signal allocation
package sig_alloc_pkg;

  localparam int DIGIT_W = 4;
  localparam int REG_W = 16;
  localparam int DIGITS = 4;
  localparam int NUM_OUT_PINS = 3;
  localparam int NUM_IN_PINS = 7;
  localparam int NUM_IN_SIGS = 7;
  localparam int NUM_OUT_SIGS = 10;
  localparam int IDX_W = 3;

  // Register indices on the parameter port
  localparam logic [2:0] IDX_INPUT_MAP_A = 3'h0;
  localparam logic [2:0] IDX_INPUT_MAP_B = 3'h1;
  localparam logic [2:0] IDX_OUTPUT_MAP_A = 3'h2;
  localparam logic [2:0] IDX_OUTPUT_MAP_B = 3'h3;
  localparam logic [2:0] IDX_OUTPUT_MAP_C = 3'h4;
  localparam logic [2:0] IDX_OUTPUT_INVERT = 3'h5;

  // Factory settings
  localparam logic [15:0] RST_INPUT_MAP_A = 16'h2100;
  localparam logic [15:0] RST_INPUT_MAP_B = 16'h6543;
  localparam logic [15:0] RST_OUTPUT_MAP_A = 16'h3211;
  localparam logic [15:0] RST_OUTPUT_MAP_B = 16'h0000;
  localparam logic [15:0] RST_OUTPUT_MAP_C = 16'h0000;
  localparam logic [15:0] RST_OUTPUT_INVERT = 16'h0000;

  // Digit codes
  localparam logic [3:0] OUT_UNUSED = 4'h0;
  localparam logic [3:0] FREE_ALLOC_ON = 4'h1;
  localparam logic [3:0] IN_ALWAYS_ON = 4'h7;
  localparam logic [3:0] IN_ALWAYS_OFF = 4'h8;
  localparam logic [3:0] IN_INV_BASE = 4'h9;

  typedef enum logic [1:0] {
    MODE_POSITION,
    MODE_SPEED,
    MODE_TORQUE
  } ctrl_mode_type;

  typedef enum logic [0:0] {
    BOOT_LOAD,
    RUN
  } boot_state_type;

  // Internal status signals, true when active
  typedef struct packed {
    logic pulse_mult_ack;
    logic near_position;
    logic warning_out;
    logic brake_release;
    logic speed_limited;
    logic torque_limited;
    logic servo_ready_out;
    logic rotation_detect;
    logic speed_match;
    logic positioning_done;
  } status_type;

  // Command inputs after allocation, true when ON
  typedef struct packed {
    logic rev_torque_limit_in;
    logic fwd_torque_limit_in;
    logic alarm_reset_in;
    logic rev_prohibit_in;
    logic fwd_prohibit_in;
    logic prop_op_in;
    logic servo_on_in;
  } seq_in_type;

  typedef struct packed {
    logic [15:0] output_invert;
    logic [15:0] output_map_c;
    logic [15:0] output_map_b;
    logic [15:0] output_map_a;
    logic [15:0] input_map_b;
    logic [15:0] input_map_a;
  } cfg_type;

endpackage
